// ===== rtl/gpio_port_defs.svh
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PIN_COUNT        8
`define ADDR_W           6

// ----------------------------------------------------------------
// primary map offsets
// ----------------------------------------------------------------
`define OFS_DIR          6'h00
`define OFS_DIR_SET      6'h01
`define OFS_DIR_CLR      6'h02
`define OFS_DIR_FLIP     6'h03
`define OFS_OUT          6'h04
`define OFS_OUT_SET      6'h05
`define OFS_OUT_CLR      6'h06
`define OFS_OUT_FLIP     6'h07
`define OFS_IN           6'h08
`define OFS_FLAGS        6'h09
`define OFS_SETUP_BASE   6'h10
`define SETUP_PAGE       3'h2

// ----------------------------------------------------------------
// alias map offsets
// ----------------------------------------------------------------
`define OFS_ALIAS_DIR    6'h20
`define OFS_ALIAS_OUT    6'h21
`define OFS_ALIAS_IN     6'h22
`define OFS_ALIAS_FLAGS  6'h23

// ----------------------------------------------------------------
// per-pin setup fields and reset values
// ----------------------------------------------------------------
`define SETUP_FLIP_BIT   7
`define SETUP_PULL_BIT   3
`define SETUP_WMASK      8'h8F
`define RST_BYTE         8'h00

// ----------------------------------------------------------------
// sense_select codes
// ----------------------------------------------------------------
`define SENSE_OFF_ON     3'h0
`define SENSE_ANY_EDGE   3'h1
`define SENSE_RISE       3'h2
`define SENSE_FALL       3'h3
`define SENSE_BUF_OFF    3'h4
`define SENSE_LOW        3'h5

`endif

// ===== rtl/gpio_port_pkg.sv
package gpio_port_pkg;

    typedef logic [7:0] port_byte_t;

    typedef struct packed {
        logic       polarity_flip;
        logic [2:0] spare;
        logic       weak_high_resistor_on;
        logic [2:0] sense_select;
    } per_pin_setup_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

endpackage

// ===== rtl/gpio_port_sense.sv
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "gpio_port_defs.svh"

// How it works
// - writing ones to the drive clear strobe clears those output bits
// - writing ones to the drive flip strobe inverts those output bits
// - reading either strobe returns the present output latch
// - input value shows each pin level while its buffer is on
// - pins with buffer off are still captured but read as zero
// - writing the input value register flips output bits written one
// - change flag sets when the pin matches its sense setting
// - writing one clears a change flag, zero leaves it
// - setup bit 7 inverts pin input and output
// - setup bit 3 turns on the pin's weak pull-up
// - sense_select decodes off, any edge, rise, fall, buffer off, low
// - eight setup registers sit at base plus pin index
// - alias map writes act exactly like primary map writes
// - alias direction shares state with the direction register
// - alias output shares state with the output latch
// - alias input write flips outputs, read gives enabled pin levels
// - alias flags show only flags of pins that source the interrupt
// - writing one to an alias flag clears the shared flag
// - direction one makes a pin output, zero input
// - output latch drives the pin only while it is an output

module gpio_port_sense (
    input  wire logic                       CLOCK,     // 100 MHz clock
    input  wire logic                       SYS_RST,   // async, high
    input  wire logic [5:0]                 BUS_ADDR,  // register offset
    input  wire logic [7:0]                 BUS_WDATA, // write data
    input  wire logic                       BUS_WR,    // write strobe
    input  wire logic                       BUS_RD,    // read strobe
    input  wire gpio_port_pkg::port_byte_t  PIN_IN,    // pin levels
    output gpio_port_pkg::port_byte_t       BUS_RDATA, // read data
    output gpio_port_pkg::port_byte_t       PIN_OUT,   // pin drive value
    output gpio_port_pkg::port_byte_t       PIN_OE_N,  // low drives pin
    output gpio_port_pkg::port_byte_t       PULLUP_EN, // pull-up on
    output logic                            IRQ        // port interrupt
);
    import gpio_port_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bus_req_t       req;
    port_byte_t     dir_reg;
    port_byte_t     dir_next;
    port_byte_t     out_reg;
    port_byte_t     out_next;
    port_byte_t     flags_reg;
    port_byte_t     flags_next;
    port_byte_t     flag_clr;
    port_byte_t     in_reg;
    port_byte_t     level_now;
    port_byte_t     hit_now;
    port_byte_t     flip_vec;
    port_byte_t     pull_vec;
    port_byte_t     source_vec;
    port_byte_t     blind_vec;
    port_byte_t     rdata_next;
    per_pin_setup_t setup_reg [0:`PIN_COUNT-1];
    logic           irq_next;

    assign req = '{wr: BUS_WR, rd: BUS_RD, addr: BUS_ADDR,
                   wdata: BUS_WDATA};

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // a pin feeds the interrupt only for real sense codes
    function automatic logic is_source(input logic [2:0] code);
        is_source = (code == `SENSE_ANY_EDGE) || (code == `SENSE_RISE) ||
                    (code == `SENSE_FALL) || (code == `SENSE_LOW);
    endfunction

    function automatic logic is_setup(input logic [5:0] a);
        is_setup = (a[5:3] == `SETUP_PAGE);
    endfunction

    // ----------------------------------------------------------------
    // per-pin sense cells
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g = g + 1) begin : g_pin
            pin_sense_cell u_cell (
                .clk     (CLOCK),
                .rst     (SYS_RST),
                .pin_raw (PIN_IN[g]),
                .setup   (setup_reg[g]),
                .level   (level_now[g]),
                .hit     (hit_now[g])
            );
            assign flip_vec[g]   = setup_reg[g].polarity_flip;
            assign pull_vec[g]   = setup_reg[g].weak_high_resistor_on;
            assign source_vec[g] = is_source(setup_reg[g].sense_select);
            assign blind_vec[g]  =
                (setup_reg[g].sense_select == `SENSE_BUF_OFF);
        end
    endgenerate

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    // each alias offset shares its branch with the matching primary one; set, clear and flip strobes have no alias
    always_comb begin
        dir_next = dir_reg;
        out_next = out_reg;
        flag_clr = 8'h00;
        if (req.wr) begin
            if (req.addr == `OFS_DIR ||
                req.addr == `OFS_ALIAS_DIR) begin
                dir_next = req.wdata;
            end else if (req.addr == `OFS_DIR_SET) begin
                dir_next = dir_reg | req.wdata;
            end else if (req.addr == `OFS_DIR_CLR) begin
                dir_next = dir_reg & ~req.wdata;
            end else if (req.addr == `OFS_DIR_FLIP) begin
                dir_next = dir_reg ^ req.wdata;
            end else if (req.addr == `OFS_OUT ||
                         req.addr == `OFS_ALIAS_OUT) begin
                out_next = req.wdata;
            end else if (req.addr == `OFS_OUT_SET) begin
                out_next = out_reg | req.wdata;
            end else if (req.addr == `OFS_OUT_CLR) begin
                out_next = out_reg & ~req.wdata;
            end else if (req.addr == `OFS_OUT_FLIP) begin
                out_next = out_reg ^ req.wdata;
            end else if (req.addr == `OFS_IN ||
                         req.addr == `OFS_ALIAS_IN) begin
                out_next = out_reg ^ req.wdata;
            end else if (req.addr == `OFS_FLAGS ||
                         req.addr == `OFS_ALIAS_FLAGS) begin
                flag_clr = req.wdata;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_reg <= `RST_BYTE;
        end else begin
            dir_reg <= dir_next;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_reg <= `RST_BYTE;
        end else begin
            out_reg <= out_next;
        end
    end

    // ----------------------------------------------------------------
    // per-pin setup registers
    // ----------------------------------------------------------------
    // unused bits 6:4 are masked so they always read zero
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < `PIN_COUNT; i++) begin
                setup_reg[i] <= `RST_BYTE;
            end
        end else if (req.wr && is_setup(req.addr)) begin
            setup_reg[req.addr[2:0]] <= req.wdata & `SETUP_WMASK;
        end
    end

    // ----------------------------------------------------------------
    // input value and change flags
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            in_reg <= `RST_BYTE;
        end else begin
            in_reg <= level_now;
        end
    end

    // a hit in the same cycle as its clear still lands
    assign flags_next = (flags_reg & ~flag_clr) | hit_now;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            flags_reg <= `RST_BYTE;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            if (req.addr == `OFS_DIR || req.addr == `OFS_DIR_SET ||
                req.addr == `OFS_DIR_CLR || req.addr == `OFS_DIR_FLIP ||
                req.addr == `OFS_ALIAS_DIR) begin
                rdata_next = dir_reg;
            end else if (req.addr == `OFS_OUT ||
                         req.addr == `OFS_OUT_SET ||
                         req.addr == `OFS_OUT_CLR ||
                         req.addr == `OFS_OUT_FLIP ||
                         req.addr == `OFS_ALIAS_OUT) begin
                rdata_next = out_reg;
            end else if (req.addr == `OFS_IN ||
                         req.addr == `OFS_ALIAS_IN) begin
                rdata_next = in_reg;
            end else if (req.addr == `OFS_FLAGS) begin
                rdata_next = flags_reg;
            end else if (req.addr == `OFS_ALIAS_FLAGS) begin
                rdata_next = flags_reg & source_vec;
            end else if (is_setup(req.addr)) begin
                rdata_next = setup_reg[req.addr[2:0]];
            end
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            BUS_RDATA <= `RST_BYTE;
        end else begin
            BUS_RDATA <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // pin drive, pull-ups, interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PIN_OUT  <= `RST_BYTE;
            PIN_OE_N <= 8'hFF;
        end else begin
            PIN_OUT  <= out_reg ^ flip_vec;
            PIN_OE_N <= ~dir_reg;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PULLUP_EN <= `RST_BYTE;
        end else begin
            PULLUP_EN <= pull_vec;
        end
    end

    // flags left over from a pin now set to no-sense stay quiet
    assign irq_next = |(flags_reg & source_vec);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking chk_cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    clear_strobe_a: assert property (
        req.wr && req.addr == `OFS_OUT_CLR |=>
        out_reg == ($past(out_reg) & ~$past(req.wdata)))
        else $error("clear strobe did not clear output bits");

    flip_strobe_a: assert property (
        req.wr && req.addr == `OFS_OUT_FLIP |=>
        out_reg == ($past(out_reg) ^ $past(req.wdata)))
        else $error("flip strobe did not invert output bits");

    strobe_read_a: assert property (
        req.rd && (req.addr == `OFS_OUT_CLR ||
                   req.addr == `OFS_OUT_FLIP) |=>
        BUS_RDATA == $past(out_reg))
        else $error("strobe read did not return output latch");

    input_read_a: assert property (
        req.rd && req.addr == `OFS_IN |=> BUS_RDATA == $past(in_reg))
        else $error("input read wrong");

    buffer_off_a: assert property (
        blind_vec != 8'h00 |=> (in_reg & $past(blind_vec)) == 8'h00)
        else $error("disabled pin shows a level");

    input_write_a: assert property (
        req.wr && req.addr == `OFS_IN |=>
        out_reg == ($past(out_reg) ^ $past(req.wdata)))
        else $error("input write did not flip output");

    flag_set_a: assert property (
        hit_now != 8'h00 |=> (flags_reg & $past(hit_now)) == $past(hit_now))
        else $error("sense hit lost");

    flag_clear_a: assert property (
        req.wr && req.addr == `OFS_FLAGS && hit_now == 8'h00 |=>
        flags_reg == ($past(flags_reg) & ~$past(req.wdata)))
        else $error("flag clear wrong");

    polarity_out_a: assert property (
        ##1 PIN_OUT == ($past(out_reg) ^ $past(flip_vec)))
        else $error("pin drive polarity wrong");

    pull_up_a: assert property (
        req.wr && req.addr == `OFS_SETUP_BASE |=> ##1
        PULLUP_EN[0] == $past(req.wdata[`SETUP_PULL_BIT], 2))
        else $error("pull-up not following setup");

    alias_out_a: assert property (
        req.wr && req.addr == `OFS_ALIAS_OUT |=> out_reg == $past(req.wdata))
        else $error("alias output write lost");

    alias_flags_a: assert property (
        req.rd && req.addr == `OFS_ALIAS_FLAGS |=>
        (BUS_RDATA & ~$past(source_vec)) == 8'h00)
        else $error("alias flag shows non-source pin");

    drive_enable_a: assert property (
        req.wr && req.addr == `OFS_DIR |=> ##1
        PIN_OE_N == ~$past(req.wdata, 2))
        else $error("drive enable not following direction");

    irq_level_a: assert property (
        ##1 IRQ == $past(|(flags_reg & source_vec)))
        else $error("interrupt line wrong");

    quiet_codes_a: assert property (
        (hit_now & ~source_vec) == 8'h00)
        else $error("non-sensing code raised a hit");

    setup_write_a: assert property (
        req.wr && req.addr == `OFS_SETUP_BASE |=>
        setup_reg[0] == ($past(req.wdata) & `SETUP_WMASK))
        else $error("setup write did not land");

    alias_dir_a: assert property (
        req.wr && req.addr == `OFS_ALIAS_DIR |=>
        dir_reg == $past(req.wdata))
        else $error("alias direction write lost");

    alias_input_a: assert property (
        req.wr && req.addr == `OFS_ALIAS_IN |=>
        out_reg == ($past(out_reg) ^ $past(req.wdata)))
        else $error("alias input write did not flip output");

    alias_clear_a: assert property (
        req.wr && req.addr == `OFS_ALIAS_FLAGS |=>
        flags_reg == (($past(flags_reg) & ~$past(req.wdata)) |
                      $past(hit_now)))
        else $error("alias flag clear wrong");

    direction_a: assert property (
        ##1 PIN_OE_N == ~$past(dir_reg))
        else $error("drive enable not matching direction");

endmodule

// ===== rtl/pin_sense_cell.sv
`timescale 1ns/10ps
`include "gpio_port_defs.svh"

module pin_sense_cell (
    input  wire logic                         clk,     // main clock
    input  wire logic                         rst,     // async, high
    input  wire logic                         pin_raw, // pin level
    input  gpio_port_pkg::per_pin_setup_t     setup,   // pin setup
    output logic                              level,   // masked level
    output logic                              hit      // sense match
);
    import gpio_port_pkg::*;

    // ------------------------------------------------------------
    // three-stage capture, change taken when stages two and three agree
    // ------------------------------------------------------------
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic stable_reg;
    logic prev_reg;
    logic buf_on;
    logic view;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg  <= 1'b0;
            sync2_reg  <= 1'b0;
            sync3_reg  <= 1'b0;
            stable_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                stable_reg <= sync3_reg;
            end
        end
    end

    assign buf_on = (setup.sense_select != `SENSE_BUF_OFF);
    assign view   = stable_reg ^ setup.polarity_flip;
    assign level  = buf_on ? view : 1'b0;

    // ------------------------------------------------------------
    // sense; history frozen while the buffer is off
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else if (buf_on) begin
            prev_reg <= view;
        end
    end

    always_comb begin
        case (setup.sense_select)
            `SENSE_ANY_EDGE: hit = view != prev_reg;
            `SENSE_RISE:     hit = view & ~prev_reg;
            `SENSE_FALL:     hit = ~view & prev_reg;
            `SENSE_LOW:      hit = ~view;
            default:         hit = 1'b0;
        endcase
    end

endmodule

// ===== verif/gpio_port_sense_test.sv
`timescale 1ns/10ps
module gpio_port_sense_test;
    import gpio_port_pkg::*;

    logic       CLOCK;
    logic       SYS_RST;
    logic [5:0] BUS_ADDR;
    port_byte_t BUS_WDATA;
    logic       BUS_WR;
    logic       BUS_RD;
    port_byte_t PIN_IN;
    port_byte_t BUS_RDATA;
    port_byte_t PIN_OUT;
    port_byte_t PIN_OE_N;
    port_byte_t PULLUP_EN;
    logic       IRQ;
    port_byte_t ext_val;
    port_byte_t ext_en;
    int         miscompares = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    gpio_port_sense u_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
        .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR),
        .BUS_RD(BUS_RD), .PIN_IN(PIN_IN), .BUS_RDATA(BUS_RDATA),
        .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
        .PULLUP_EN(PULLUP_EN), .IRQ(IRQ));

    pin_world u_pins (.clk(CLOCK), .drive_val(PIN_OUT),
        .oe_n(PIN_OE_N), .pull_on(PULLUP_EN), .ext_val(ext_val),
        .ext_en(ext_en), .pad(PIN_IN));

    initial CLOCK = 1'b0;
    always #5 CLOCK = ~CLOCK;

    // ----------------------------------------------------------------
    // hang guard and shared tasks
    // ----------------------------------------------------------------
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input port_byte_t exp,
                       input port_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [5:0] a, input port_byte_t d);
        @(posedge CLOCK);
        BUS_WR    <= 1'b1;
        BUS_ADDR  <= a;
        BUS_WDATA <= d;
        @(posedge CLOCK);
        BUS_WR    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input port_byte_t exp);
        @(posedge CLOCK);
        BUS_RD   <= 1'b1;
        BUS_ADDR <= a;
        @(posedge CLOCK);
        BUS_RD   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, BUS_RDATA);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask

    task automatic pins(input port_byte_t v, input port_byte_t en);
        @(posedge CLOCK);
        ext_val <= v;
        ext_en  <= en;
        wait_cyc(8);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [5:0] offs [12] = '{6'h00, 6'h04, 6'h06, 6'h07, 6'h08,
            6'h09, 6'h10, 6'h17, 6'h20, 6'h23, 6'h0C, 6'h3F};
        chk("oe_n", 8'hFF, PIN_OE_N);
        chk("pin_out", 8'h00, PIN_OUT);
        foreach (offs[i]) rd(offs[i], 8'h00);
        wr(6'h0C, 8'hFF);
        rd(6'h0C, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_out();
        wr(6'h04, 8'hA5);
        wr(6'h06, 8'h0F);
        rd(6'h06, 8'hA0);
        rd(6'h07, 8'hA0);
        wr(6'h07, 8'hFF);
        rd(6'h04, 8'h5F);
        wr(6'h08, 8'h03);
        rd(6'h08, 8'h00);
        rd(6'h04, 8'h5C);
        wr(6'h22, 8'h80);
        rd(6'h21, 8'hDC);
        wait_cyc(1);
        chk("pin_out", 8'hDC, PIN_OUT);
        wr(6'h21, 8'h3C);
        rd(6'h04, 8'h3C);
        $display("test output strobes done");
    endtask

    task automatic t_dir();
        wr(6'h20, 8'h0F);
        rd(6'h00, 8'h0F);
        wait_cyc(1);
        chk("oe_n", 8'hF0, PIN_OE_N);
        pins(8'hA0, 8'hF0);
        rd(6'h08, 8'hAC);
        rd(6'h22, 8'hAC);
        $display("test direction done");
    endtask

    task automatic t_setup();
        for (int n = 0; n < 8; n++) wr(6'h10 + 6'(n), 8'h08);
        wait_cyc(1);
        chk("pullup", 8'hFF, PULLUP_EN);
        for (int n = 0; n < 8; n++) wr(6'h10 + 6'(n), 8'h00);
        wr(6'h16, 8'hFF);
        rd(6'h16, 8'h8F);
        wr(6'h16, 8'h00);
        wr(6'h17, 8'h88);
        pins(8'hA0, 8'h70);
        rd(6'h08, 8'h2C);
        chk("pin_out", 8'hBC, PIN_OUT);
        chk("pullup", 8'h80, PULLUP_EN);
        $display("test pin setup done");
    endtask

    task automatic t_sense();
        pins(8'hC0, 8'hF0);
        wr(6'h14, 8'h01);
        wr(6'h15, 8'h02);
        wr(6'h16, 8'h03);
        wr(6'h17, 8'h05);
        wait_cyc(8);
        wr(6'h09, 8'hFF);
        rd(6'h09, 8'h00);
        chk("irq", 8'h00, {7'h00, IRQ});
        pins(8'h10, 8'hF0);
        rd(6'h09, 8'hD0);
        chk("irq", 8'h01, {7'h00, IRQ});
        rd(6'h23, 8'hD0);
        wr(6'h23, 8'h50);
        rd(6'h09, 8'h80);
        wr(6'h09, 8'h80);
        rd(6'h09, 8'h80);
        pins(8'hE0, 8'hF0);
        rd(6'h09, 8'hB0);
        wr(6'h14, 8'h00);
        rd(6'h23, 8'hA0);
        rd(6'h09, 8'hB0);
        wr(6'h09, 8'hFF);
        rd(6'h09, 8'h00);
        chk("irq", 8'h00, {7'h00, IRQ});
        wr(6'h15, 8'h04);
        pins(8'hC0, 8'hF0);
        pins(8'hE0, 8'hF0);
        rd(6'h09, 8'h00);
        rd(6'h08, 8'hCC);
        $display("test sense done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        SYS_RST   = 1'b1;
        BUS_ADDR  = 6'h00;
        BUS_WDATA = 8'h00;
        BUS_WR    = 1'b0;
        BUS_RD    = 1'b0;
        ext_val   = 8'h00;
        ext_en    = 8'hFF;
        repeat (4) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        wait_cyc(1);
        t_reset();
        t_out();
        t_dir();
        t_setup();
        t_sense();
        tally_and_finish();
    end
endmodule

// ===== verif/pin_world.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// outside world of the port pins
// ----------------------------------------------------------------
module pin_world (
    input  wire logic       clk,       // main clock
    input  wire logic [7:0] drive_val, // device drive value
    input  wire logic [7:0] oe_n,      // low: device drives
    input  wire logic [7:0] pull_on,   // device pull-up request
    input  wire logic [7:0] ext_val,   // outside driver level
    input  wire logic [7:0] ext_en,    // outside driver on
    output logic      [7:0] pad        // resolved pin level
);
    logic [7:0] float_pat = 8'h55;

    // a floating pin must never look like a settled level
    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n[i])
                pad[i] = drive_val[i];
            else if (ext_en[i])
                pad[i] = ext_val[i];
            else if (pull_on[i])
                pad[i] = 1'b1;
            else
                pad[i] = float_pat[i];
        end
    end
endmodule
